/* rtl/fmu_top.sv */
// Floating-point move/multiply/negate unit with a Wishbone register port
`timescale 1ns/1ps
module fmu_top #(
    parameter int ADR_W = 8
) (
    // Clock and reset
    input  wire logic             CLK_SYS,
    input  wire logic             RESETN,
    // Wishbone slave
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]       WB_SEL_I,
    input  wire logic [31:0]      WB_DAT_I,
    output logic      [31:0]      WB_DAT_O,
    output logic                  WB_ACK_O,
    // Core condition flags N Z C V
    output logic      [3:0]       CORE_FLAGS
);
    generate
        if (ADR_W < 8) begin : g_adr_chk
            $error("fmu_top: ADR_W must be at least 8");
        end
    endgenerate

    typedef struct packed {
        fmu_pkg::fmu_state_t st;
        logic [31:0]         cmd;
        logic [4:0]          dst;
        logic [31:0]         in0;
        logic [31:0]         in1;
        logic [31:0]         out0;
        logic [31:0]         out1;
        logic [31:0]         stat_ctrl;
        logic [31:0]         prod;
        logic [3:0]          nzcv;
        logic                done;
        logic                inval;
        logic                ack;
        logic [31:0]         rdat;
        logic [31:0][31:0]   sreg;
    } fmu_regs_t;

    fmu_regs_t r_r;
    fmu_regs_t r_nxt;

    logic [31:0] mul_p;
    logic [31:0] add_a;
    logic [31:0] add_b;
    logic [31:0] add_s;
    fmu_pkg::fmu_op_t cur_op;

    function automatic logic [31:0] fmu_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            fmu_merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    // Expand the 8-bit encoded constant to single precision
    function automatic logic [31:0] fmu_imm(input logic [7:0] v);
        fmu_imm = {v[7], ~v[6], {5{v[6]}}, v[5:4], v[3:0], 19'h0};
    endfunction

    function automatic logic fmu_bad_core(input logic [3:0] n);
        fmu_bad_core = (n == fmu_pkg::CORE_SP) || (n == fmu_pkg::CORE_PC);
    endfunction

    assign cur_op = fmu_pkg::fmu_op_t'(r_r.cmd[fmu_pkg::OP_HI:fmu_pkg::OP_LO]);

    // Operands of the current arithmetic command
    fmu_fmul u_mul (
        .a (r_r.sreg[r_r.cmd[fmu_pkg::SRC1_HI:fmu_pkg::SRC1_LO]]),
        .b (r_r.sreg[r_r.cmd[fmu_pkg::SRC2_HI:fmu_pkg::SRC2_LO]]),
        .p (mul_p)
    );

    // Destination and rounded product, each with its own sign flip
    always_comb begin
        add_a = r_r.sreg[r_r.dst];
        add_b = r_r.prod;
        unique case (cur_op)
            fmu_pkg::OP_MUL_SUB: begin
                add_b[fmu_pkg::SIGN_BIT] = ~r_r.prod[fmu_pkg::SIGN_BIT];
            end
            fmu_pkg::OP_NEG_MUL_ACC: begin
                add_a[fmu_pkg::SIGN_BIT] = ~r_r.sreg[r_r.dst][fmu_pkg::SIGN_BIT];
                add_b[fmu_pkg::SIGN_BIT] = ~r_r.prod[fmu_pkg::SIGN_BIT];
            end
            fmu_pkg::OP_NEG_MUL_SUB: begin
                add_a[fmu_pkg::SIGN_BIT] = ~r_r.sreg[r_r.dst][fmu_pkg::SIGN_BIT];
            end
            default: begin
            end
        endcase
    end

    fmu_fadd u_add (
        .a (add_a),
        .b (add_b),
        .s (add_s)
    );

    always_comb begin
        logic                 acc;
        logic                 wr;
        logic [7:0]           ofs;
        logic [31:0]          old;
        logic [31:0]          wd;
        logic [4:0]           f_dst;
        logic [4:0]           f_s1;
        logic [4:0]           f_s2;
        logic [3:0]           f_rt;
        logic [3:0]           f_rt2;
        logic                 bad;
        fmu_pkg::fmu_op_t     op;
        acc   = 1'b0;
        wr    = 1'b0;
        ofs   = 8'h00;
        old   = 32'h0;
        wd    = 32'h0;
        f_dst = 5'h00;
        f_s1  = 5'h00;
        f_s2  = 5'h00;
        f_rt  = 4'h0;
        f_rt2 = 4'h0;
        bad   = 1'b0;
        op    = fmu_pkg::OP_MUL_ACC;
        r_nxt = r_r;
        r_nxt.ack = 1'b0;

        acc = WB_CYC_I && WB_STB_I && !r_r.ack;
        wr  = acc && WB_WE_I;
        ofs = WB_ADR_I[7:0];

        // Read mux; unmapped offsets read zero and take no write
        if (acc) begin
            r_nxt.ack  = 1'b1;
            r_nxt.rdat = 32'h0;
            if (ofs[fmu_pkg::FPREG_WIN_BIT]) begin
                r_nxt.rdat = r_r.sreg[ofs[6:2]];
            end else begin
                unique case ({ofs[7:2], 2'b00})
                    fmu_pkg::REG_CMD:         r_nxt.rdat = r_r.cmd;
                    fmu_pkg::REG_CORE_IN0:    r_nxt.rdat = r_r.in0;
                    fmu_pkg::REG_CORE_IN1:    r_nxt.rdat = r_r.in1;
                    fmu_pkg::REG_CORE_OUT0:   r_nxt.rdat = r_r.out0;
                    fmu_pkg::REG_CORE_OUT1:   r_nxt.rdat = r_r.out1;
                    fmu_pkg::REG_STATUS_CTRL: r_nxt.rdat = r_r.stat_ctrl;
                    fmu_pkg::REG_STATE: begin
                        r_nxt.rdat[fmu_pkg::ST_BUSY_BIT]  = (r_r.st != fmu_pkg::ST_IDLE);
                        r_nxt.rdat[fmu_pkg::ST_DONE_BIT]  = r_r.done;
                        r_nxt.rdat[fmu_pkg::ST_INVAL_BIT] = r_r.inval;
                        r_nxt.rdat[fmu_pkg::ST_FLAGS_HI:fmu_pkg::ST_FLAGS_LO] = r_r.nzcv;
                    end
                    default: r_nxt.rdat = 32'h0;
                endcase
            end
        end

        // Software may poke the register file only while idle
        if (wr && ofs[fmu_pkg::FPREG_WIN_BIT] && r_r.st == fmu_pkg::ST_IDLE) begin
            r_nxt.sreg[ofs[6:2]] = fmu_merge(r_r.sreg[ofs[6:2]], WB_DAT_I, WB_SEL_I);
        end
        if (wr && {ofs[7:2], 2'b00} == fmu_pkg::REG_CORE_IN0) begin
            r_nxt.in0 = fmu_merge(r_r.in0, WB_DAT_I, WB_SEL_I);
        end
        if (wr && {ofs[7:2], 2'b00} == fmu_pkg::REG_CORE_IN1) begin
            r_nxt.in1 = fmu_merge(r_r.in1, WB_DAT_I, WB_SEL_I);
        end

        // Command launch; a command written while busy is dropped
        if (wr && {ofs[7:2], 2'b00} == fmu_pkg::REG_CMD && r_r.st == fmu_pkg::ST_IDLE) begin
            old   = r_r.cmd;
            wd    = fmu_merge(old, WB_DAT_I, WB_SEL_I);
            op    = fmu_pkg::fmu_op_t'(wd[fmu_pkg::OP_HI:fmu_pkg::OP_LO]);
            f_dst = wd[fmu_pkg::DST_HI:fmu_pkg::DST_LO];
            f_s1  = wd[fmu_pkg::SRC1_HI:fmu_pkg::SRC1_LO];
            f_s2  = wd[fmu_pkg::SRC2_HI:fmu_pkg::SRC2_LO];
            f_rt  = wd[fmu_pkg::RT_HI:fmu_pkg::RT_LO];
            f_rt2 = wd[fmu_pkg::RT2_HI:fmu_pkg::RT2_LO];
            r_nxt.cmd   = wd;
            r_nxt.done  = 1'b0;
            r_nxt.inval = 1'b0;
            r_nxt.dst   = f_dst;

            // Refuse PC/SP as core operand, and a pair running off the end
            unique case (op)
                fmu_pkg::OP_DBL_TO_CORE, fmu_pkg::OP_SGL_CORE, fmu_pkg::OP_CORE_TO_DBL,
                fmu_pkg::OP_CORE_TO_STAT: begin
                    bad = fmu_bad_core(f_rt);
                end
                fmu_pkg::OP_STAT_TO_CORE: begin
                    bad = !wd[fmu_pkg::FLAG_FORM_BIT] && fmu_bad_core(f_rt);
                end
                fmu_pkg::OP_PAIR_CORE: begin
                    bad = fmu_bad_core(f_rt) || fmu_bad_core(f_rt2)
                          || f_s2 == fmu_pkg::LAST_SINGLE;
                end
                default: bad = (wd[fmu_pkg::OP_HI:fmu_pkg::OP_LO] == 4'hF);
            endcase

            // Nothing below writes nzcv except the flag form
            if (bad) begin
                r_nxt.inval = 1'b1;
            end else begin
                unique case (op)
                    fmu_pkg::OP_MUL_ACC, fmu_pkg::OP_MUL_SUB, fmu_pkg::OP_NEG_MUL_ACC,
                    fmu_pkg::OP_NEG_MUL_SUB: begin
                        r_nxt.st = fmu_pkg::ST_MUL;
                    end
                    fmu_pkg::OP_MULTIPLY, fmu_pkg::OP_NEG_MULTIPLY: begin
                        r_nxt.st = fmu_pkg::ST_MUL;
                        if (wd[fmu_pkg::NO_DEST_BIT]) begin
                            r_nxt.dst = f_s1;
                        end
                    end
                    fmu_pkg::OP_MOVE_IMM: begin
                        r_nxt.sreg[f_dst] = fmu_imm(wd[fmu_pkg::IMM_HI:fmu_pkg::IMM_LO]);
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_MOVE_REG: begin
                        if (wd[fmu_pkg::DBL_BIT]) begin
                            r_nxt.sreg[{f_dst[3:0], 1'b0}] = r_r.sreg[{f_s2[3:0], 1'b0}];
                            r_nxt.sreg[{f_dst[3:0], 1'b1}] = r_r.sreg[{f_s2[3:0], 1'b1}];
                        end else begin
                            r_nxt.sreg[f_dst] = r_r.sreg[f_s2];
                        end
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_DBL_TO_CORE: begin
                        r_nxt.out0 = r_r.sreg[{f_s1[3:0], wd[fmu_pkg::HALF_BIT]}];
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_SGL_CORE: begin
                        if (wd[fmu_pkg::TO_CORE_BIT]) begin
                            r_nxt.out0 = r_r.sreg[f_s1];
                        end else begin
                            r_nxt.sreg[f_s1] = r_r.in0;
                        end
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_PAIR_CORE: begin
                        if (wd[fmu_pkg::TO_CORE_BIT]) begin
                            r_nxt.out0 = r_r.sreg[f_s2];
                            r_nxt.out1 = r_r.sreg[f_s2 + 5'h01];
                        end else begin
                            r_nxt.sreg[f_s2]          = r_r.in0;
                            r_nxt.sreg[f_s2 + 5'h01] = r_r.in1;
                        end
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_CORE_TO_DBL: begin
                        r_nxt.sreg[{f_dst[3:0], wd[fmu_pkg::HALF_BIT]}] = r_r.in0;
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_STAT_TO_CORE: begin
                        if (wd[fmu_pkg::FLAG_FORM_BIT]) begin
                            r_nxt.nzcv = r_r.stat_ctrl[fmu_pkg::SC_FLAGS_HI:fmu_pkg::SC_FLAGS_LO];
                        end else begin
                            r_nxt.out0 = r_r.stat_ctrl;
                        end
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_CORE_TO_STAT: begin
                        r_nxt.stat_ctrl = r_r.in0;
                        r_nxt.done = 1'b1;
                    end
                    fmu_pkg::OP_NEGATE: begin
                        r_nxt.sreg[f_dst] = {~r_r.sreg[f_s2][fmu_pkg::SIGN_BIT],
                                             r_r.sreg[f_s2][fmu_pkg::SIGN_BIT-1:0]};
                        r_nxt.done = 1'b1;
                    end
                endcase
            end
        end

        // Multiply stage; the product is rounded here, before any add
        unique case (r_r.st)
            fmu_pkg::ST_IDLE: begin
            end
            fmu_pkg::ST_MUL: begin
                r_nxt.prod = mul_p;
                if (cur_op == fmu_pkg::OP_MULTIPLY) begin
                    r_nxt.sreg[r_r.dst] = mul_p;
                    r_nxt.done = 1'b1;
                    r_nxt.st   = fmu_pkg::ST_IDLE;
                end else if (cur_op == fmu_pkg::OP_NEG_MULTIPLY) begin
                    r_nxt.sreg[r_r.dst] = {~mul_p[fmu_pkg::SIGN_BIT],
                                           mul_p[fmu_pkg::SIGN_BIT-1:0]};
                    r_nxt.done = 1'b1;
                    r_nxt.st   = fmu_pkg::ST_IDLE;
                end else begin
                    r_nxt.st = fmu_pkg::ST_ADD;
                end
            end
            fmu_pkg::ST_ADD: begin
                r_nxt.sreg[r_r.dst] = add_s;
                r_nxt.done = 1'b1;
                r_nxt.st   = fmu_pkg::ST_IDLE;
            end
            default: begin
                r_nxt.st = fmu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            r_r           <= '0;
            r_r.stat_ctrl <= fmu_pkg::STATUS_CTRL_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign WB_DAT_O   = r_r.rdat;
    assign WB_ACK_O   = r_r.ack;
    assign CORE_FLAGS = r_r.nzcv;
endmodule // fmu_top

/* shared/fmu_pkg.sv */
// Constants, field layout and types of the floating-point move/multiply/negate unit
package fmu_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_CORE_IN0 = 8'h04;
    localparam logic [7:0]  REG_CORE_IN1 = 8'h08;
    localparam logic [7:0]  REG_CORE_OUT0 = 8'h0C;
    localparam logic [7:0]  REG_CORE_OUT1 = 8'h10;
    localparam logic [7:0]  REG_STATUS_CTRL = 8'h14;
    localparam logic [7:0]  REG_STATE    = 8'h18;
    localparam int          FPREG_WIN_BIT = 7;
    localparam logic [31:0] STATUS_CTRL_RST = 32'h0000_0000;
    // Command word fields
    localparam int OP_LO = 0;
    localparam int OP_HI = 3;
    localparam int DST_LO = 4;
    localparam int DST_HI = 8;
    localparam int SRC1_LO = 9;
    localparam int SRC1_HI = 13;
    localparam int SRC2_LO = 14;
    localparam int SRC2_HI = 18;
    localparam int IMM_LO = 9;
    localparam int IMM_HI = 16;
    localparam int HALF_BIT = 19;
    localparam int DBL_BIT = 20;
    localparam int RT_LO = 21;
    localparam int RT_HI = 24;
    localparam int RT2_LO = 25;
    localparam int RT2_HI = 28;
    localparam int TO_CORE_BIT = 29;
    localparam int FLAG_FORM_BIT = 30;
    localparam int NO_DEST_BIT = 31;
    // Status word bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_INVAL_BIT = 2;
    localparam int ST_FLAGS_LO = 4;
    localparam int ST_FLAGS_HI = 7;
    // Flags inside the status/control register
    localparam int SC_FLAGS_LO = 28;
    localparam int SC_FLAGS_HI = 31;
    // Forbidden core register numbers, and the last single register
    localparam logic [3:0] CORE_SP = 4'hD;
    localparam logic [3:0] CORE_PC = 4'hF;
    localparam logic [4:0] LAST_SINGLE = 5'h1F;
    // Single-precision layout
    localparam int SIGN_BIT = 31;
    localparam int EXP_LO = 23;
    localparam int EXP_HI = 30;
    localparam logic [7:0]  EXP_MAX = 8'hFF;
    localparam logic [9:0]  EXP_BIAS = 10'h07F;
    localparam logic [31:0] QNAN = 32'h7FC0_0000;

    typedef enum logic [3:0] {
        OP_MUL_ACC      = 4'b0000,
        OP_MUL_SUB      = 4'b0001,
        OP_MOVE_IMM     = 4'b0010,
        OP_MOVE_REG     = 4'b0011,
        OP_DBL_TO_CORE  = 4'b0100,
        OP_SGL_CORE     = 4'b0101,
        OP_PAIR_CORE    = 4'b0110,
        OP_CORE_TO_DBL  = 4'b0111,
        OP_STAT_TO_CORE = 4'b1000,
        OP_CORE_TO_STAT = 4'b1001,
        OP_MULTIPLY     = 4'b1010,
        OP_NEGATE       = 4'b1011,
        OP_NEG_MUL_ACC  = 4'b1100,
        OP_NEG_MUL_SUB  = 4'b1101,
        OP_NEG_MULTIPLY = 4'b1110
    } fmu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MUL  = 2'b01,
        ST_ADD  = 2'b10
    } fmu_state_t;
endpackage

/* rtl/fmu_fmul.sv */
// Single-precision multiplier, round to nearest even, denormals flushed
`timescale 1ns/1ps
module fmu_fmul (
    // Operands
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    // Rounded product
    output logic      [31:0] p
);
    logic [47:0] m;
    logic [23:0] mt;
    logic [24:0] rm;
    logic [9:0]  e;
    logic        g;
    logic        st;
    logic        sg;

    always_comb begin
        sg = a[fmu_pkg::SIGN_BIT] ^ b[fmu_pkg::SIGN_BIT];
        m  = {1'b1, a[fmu_pkg::EXP_LO-1:0]} * {1'b1, b[fmu_pkg::EXP_LO-1:0]};
        e  = {2'b00, a[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO]} + {2'b00, b[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO]}
             - fmu_pkg::EXP_BIAS;
        if (m[47]) begin
            mt = m[47:24];
            g  = m[23];
            st = |m[22:0];
            e  = e + 10'h001;
        end else begin
            mt = m[46:23];
            g  = m[22];
            st = |m[21:0];
        end
        rm = {1'b0, mt} + {24'h0, g & (st | mt[0])};
        if (rm[24]) begin
            e = e + 10'h001;
        end
        p = {sg, e[7:0], rm[24] ? 23'h0 : rm[22:0]};
        // Specials first: NaN/inf win over zero, zero over range checks
        if (a[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == fmu_pkg::EXP_MAX
            || b[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == fmu_pkg::EXP_MAX) begin
            p = (|a[fmu_pkg::EXP_LO-1:0] && a[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == fmu_pkg::EXP_MAX)
                || (|b[fmu_pkg::EXP_LO-1:0] && b[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == fmu_pkg::EXP_MAX)
                ? fmu_pkg::QNAN : {sg, fmu_pkg::EXP_MAX, 23'h0};
        end else if (a[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == 8'h00
                     || b[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == 8'h00 || e[9] || e == 10'h000) begin
            p = {sg, 31'h0};
        end else if (e >= {2'b00, fmu_pkg::EXP_MAX}) begin
            p = {sg, fmu_pkg::EXP_MAX, 23'h0};
        end
    end
endmodule // fmu_fmul

/* rtl/fmu_fadd.sv */
// Single-precision adder, round to nearest even, denormals flushed
`timescale 1ns/1ps
module fmu_fadd (
    // Operands
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    // Rounded sum
    output logic      [31:0] s
);
    logic [31:0] bg;
    logic [31:0] sm;
    logic [7:0]  d;
    logic [52:0] wide;
    logic [27:0] sum;
    logic [26:0] nm;
    logic [24:0] rm;
    logic [9:0]  e;
    logic [4:0]  lz;

    always_comb begin
        bg   = (a[30:0] >= b[30:0]) ? a : b;
        sm   = (a[30:0] >= b[30:0]) ? b : a;
        d    = bg[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] - sm[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO];
        e    = {2'b00, bg[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO]};
        // Wide shift keeps a sticky bit for all but huge exponent gaps
        wide = (sm[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == 8'h00) ? 53'h0
               : {1'b1, sm[fmu_pkg::EXP_LO-1:0], 29'h0} >> d;
        if (bg[fmu_pkg::SIGN_BIT] ^ sm[fmu_pkg::SIGN_BIT]) begin
            sum = {2'b01, bg[fmu_pkg::EXP_LO-1:0], 3'b000} - {1'b0, wide[52:27], |wide[26:0]};
        end else begin
            sum = {2'b01, bg[fmu_pkg::EXP_LO-1:0], 3'b000} + {1'b0, wide[52:27], |wide[26:0]};
        end
        lz = 5'h00;
        for (int i = 0; i < 27; i++) begin
            if (sum[i]) begin
                lz = 5'(26 - i);
            end
        end
        if (sum[27]) begin
            nm = {sum[27:2], sum[1] | sum[0]};
            e  = e + 10'h001;
        end else begin
            nm = sum[26:0] << lz;
            e  = e - {5'h00, lz};
        end
        rm = {1'b0, nm[26:3]} + {24'h0, nm[2] & (nm[1] | nm[0] | nm[3])};
        if (rm[24]) begin
            e = e + 10'h001;
        end
        s = {bg[fmu_pkg::SIGN_BIT], e[7:0], rm[24] ? 23'h0 : rm[22:0]};
        // Infinity minus infinity is not flagged: the larger operand passes
        if (bg[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == fmu_pkg::EXP_MAX) begin
            s = bg;
        end else if (bg[fmu_pkg::EXP_HI:fmu_pkg::EXP_LO] == 8'h00) begin
            s = {a[fmu_pkg::SIGN_BIT] & b[fmu_pkg::SIGN_BIT], 31'h0};
        end else if (sum == 28'h0) begin
            s = 32'h0;
        end else if (e[9] || e == 10'h000) begin
            s = {bg[fmu_pkg::SIGN_BIT], 31'h0};
        end else if (e >= {2'b00, fmu_pkg::EXP_MAX}) begin
            s = {bg[fmu_pkg::SIGN_BIT], fmu_pkg::EXP_MAX, 23'h0};
        end
    end
endmodule // fmu_fadd

/* verif/fmu_monitor.sv */
// Bus and flag checks for the move/multiply/negate unit
`timescale 1ns/1ps
module fmu_monitor #(
    parameter int ADR_W = 8
) (
    input wire logic             CLK_SYS,
    input wire logic             RESETN,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic             WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0]       WB_SEL_I,
    input wire logic [31:0]      WB_DAT_I,
    input wire logic [31:0]      WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic [3:0]       CORE_FLAGS
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_idle;
        !(WB_CYC_I && WB_STB_I);
    endsequence
    a_ack_next: assert property (s_req |=> WB_ACK_O) else $error("ack late");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack unasked");
    a_flag_cause: assert property ($changed(CORE_FLAGS) |-> WB_ACK_O && $past(WB_WE_I && WB_ADR_I == 8'h00
        && WB_DAT_I[3:0] == 4'h8 && WB_DAT_I[30])) else $error("flags moved");
    a_hole_zero: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I >= 8'h1C && WB_ADR_I < 8'h80)
        |-> WB_DAT_O == 32'h0) else $error("hole not zero");
    a_reset_quiet: assert property ($rose(RESETN) |-> !WB_ACK_O && CORE_FLAGS == 4'h0) else $error("reset dirty");
    a_state_flags: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 8'h18)
        |-> WB_DAT_O[7:4] == CORE_FLAGS) else $error("state flags");
    a_dat_hold: assert property (s_idle ##1 s_idle |-> $stable(WB_DAT_O)) else $error("data drift");
endmodule // fmu_monitor

bind fmu_top fmu_monitor #(.ADR_W(ADR_W)) mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CORE_FLAGS(CORE_FLAGS));

/* verif/fmu_core_model.sv */
// Integer core side: register file and condition flags
`timescale 1ns/1ps
module fmu_core_model (
    // Clock and flags from the unit
    input wire logic       clk,
    input wire logic [3:0] flags_in
);
    // Never handed out as sp or pc, pairs need not be adjacent
    logic [31:0] regs [16];
    logic [3:0]  apsr_r;
    // Flags follow the unit only
    always @(posedge clk) apsr_r <= flags_in;
endmodule // fmu_core_model

/* verif/fmu_top_tb.sv */
// Self-checking bench for the move/multiply/negate unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; $display("BAD %s %h %h", n, e, g); end end
module fmu_top_tb;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, seed = 32'h11, r, r2, q_e;
    logic [3:0]  flags;
    logic [31:0] exp_q [$];
    int          err_count = 0, check_count = 0;
    logic [3:0]  ops [6] = '{4'h0, 4'h1, 4'hA, 4'hC, 4'hD, 4'hE};
    logic [31:0] res [6] = '{32'h40E00000, 32'hC0A00000, 32'h40C00000, 32'hC0E00000, 32'h40A00000, 32'hC0C00000};
    always #2 clk = ~clk;
    fmu_top #(.ADR_W(8)) dut (.CLK_SYS(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CORE_FLAGS(flags));
    fmu_core_model core (.clk(clk), .flags_in(flags));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // Longest command settles two edges after its ack
    task cmd(input logic [31:0] c);
        wb(1'b1, 8'h00, c);
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
        q_e = exp_q.pop_front();
        `CHK("rdat", q_e, rdat)
    end
    task wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #80000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, 8'h84, 32'h40000000);
            wb(1'b1, 8'h88, 32'h40400000);
            wb(1'b1, 8'h8C, 32'h3F800000);
            cmd({13'h0, 5'd2, 5'd1, 5'd3, ops[i]});
            rd(8'h8C, res[i]);
        end
        cmd({13'h0, 5'd1, 5'd0, 5'd4, 4'hB});
        rd(8'h90, 32'hC0000000);
        cmd({15'h0, 8'h70, 5'd7, 4'h2});
        rd(8'h9C, 32'h3F800000);
        $display("arith done");
        r = xs(seed);
        r2 = xs(r);
        core.regs[1] = r;
        wb(1'b1, 8'h04, core.regs[1]);
        cmd({11'h001, 2'b0, 5'd0, 5'd5, 5'd0, 4'h5});
        rd(8'h94, r);
        cmd({11'h102, 2'b0, 5'd0, 5'd5, 5'd0, 4'h5});
        rd(8'h0C, r);
        cmd({11'h0, 2'b0, 5'd5, 5'd0, 5'd6, 4'h3});
        rd(8'h98, r);
        cmd({11'h0, 2'b10, 5'd2, 5'd0, 5'd4, 4'h3});
        rd(8'hA0, 32'hC0000000);
        rd(8'hA4, r);
        for (int x = 0; x < 2; x++) begin
            cmd({11'h001, 1'b0, x[0], 5'd0, 5'd2, 5'd0, 4'h4});
            rd(8'h0C, x ? r : 32'hC0000000);
        end
        wb(1'b1, 8'h04, r2);
        cmd({13'h0, 5'd0, 5'd0, 5'd2, 4'h7});
        rd(8'h90, r2);
        rd(8'h94, r);
        cmd({11'h160, 2'b0, 5'd4, 5'd0, 5'd0, 4'h6});
        rd(8'h0C, r2);
        rd(8'h10, r);
        for (int k = 0; k < 2; k++) begin
            cmd({7'h0, k ? 4'd15 : 4'd13, 2'b0, 5'd0, 5'd5, 5'd0, 4'h5});
            rd(8'h94, r);
            rd(8'h18, 32'h00000004);
        end
        $display("moves done");
        wb(1'b1, 8'h04, 32'hA0000000);
        cmd({7'h0, 4'd1, 17'h0, 4'h9});
        rd(8'h14, 32'hA0000000);
        cmd({7'h0, 4'd2, 17'h0, 4'h8});
        rd(8'h0C, 32'hA0000000);
        cmd(32'h40000008);
        `CHK("flags", 4'hA, core.apsr_r)
        rd(8'h40, 32'h0);
        wb(1'b1, 8'h84, 32'h40000000);
        cmd({1'b1, 12'h0, 5'd2, 5'd1, 5'd0, 4'hA});
        rd(8'h84, 32'h40C00000);
        $display("status done");
        @(posedge clk);
        wrap_up();
    end
endmodule // fmu_top_tb
